/* File: src/wicl_consts.vh */
// Purpose: constants for the wake and indicator configuration loader
// Assumes: configuration bytes arrive one per strobe with a byte index
// Notes: register offsets are word aligned byte addresses
//
// Behaviour
// - wake flags0 bit 3 picks wake pin driver, open drain or push-pull.
// - wake flags0 bit 2 accepts link-change as a wake source.
// - wake flags0 bit 1 enables wake-packet detection and wakeup.
// - wake flags0 bit 0 enables exact address detection and wakeup.
// - with master enable clear, flags0 bits 3..0 are disregarded.
// - both wake flag bytes seed the flag attributes register defaults.
// - wake flags1 bit 6 picks attach pin driver; ignored when attach disabled.
// - wake flags1 bit 5 asserts attach pin once controller is ready.
// - wake flags1 bit 4 sets attach pin active level; ignored when disabled.
// - wake flags1 bit 1 enables broadcast-packet detection and wakeup.
// - wake flags1 bit 0 enables wake frames and loads wake frame filter 0.
// - attach pin function is driven only in HSIC operation.
// - indicator byte0 bits 3..0 enable indicator pins, hardware config defaults.
// - indicator byte1 high nibble to indicator1 select, low to indicator0.
// - indicator byte2 high nibble to indicator3 select, low to indicator2.
// - indicator byte3 becomes behaviour register bits 7..0 default.
// - mode and behaviour registers keep software values while protection set.
// - wake flags0 bit 7 is master enable for wake pin events.
// - wake flags0 bit 4 sets wake signal polarity.
// - pulse length 1.5 ms or 150 ms by bit 5; not extended.
`ifndef WICL_CONSTS_VH
`define WICL_CONSTS_VH
// byte indices of the configuration stream
`define WICL_IDX_WAKE0 3'h0
`define WICL_IDX_WAKE1 3'h1
`define WICL_IDX_IND0 3'h2
`define WICL_IDX_IND1 3'h3
`define WICL_IDX_IND2 3'h4
`define WICL_IDX_IND3 3'h5
// wake flags 0 fields
`define WICL_W0_MASTER 7
`define WICL_W0_PULSE 6
`define WICL_W0_LONG 5
`define WICL_W0_POL 4
`define WICL_W0_PP 3
`define WICL_W0_LINK 2
`define WICL_W0_PKT 1
`define WICL_W0_EXACT 0
// wake flags 1 fields
`define WICL_W1_PP 6
`define WICL_W1_EN 5
`define WICL_W1_POL 4
`define WICL_W1_BCAST 1
`define WICL_W1_FRAME 0
`define WICL_W1_MASK 8'h73
`define WICL_IND0_MASK 8'h0F
// register byte addresses
`define WICL_REG_FLAG_ATTRIBUTES_REG 4'h0
`define WICL_REG_HARDWARE_CONFIG_REG 4'h4
`define WICL_REG_IND_MODE 4'h8
`define WICL_REG_IND_BEH 4'hC
`define WICL_HW_PROTECT 8
// pulse timing, microseconds, at 200 MHz
`define WICL_CLK_MHZ 200
`define WICL_PULSE_SHORT_US 1500
`define WICL_PULSE_LONG_US 150000
`define WICL_PULSE_SHORT_CYC (`WICL_PULSE_SHORT_US * `WICL_CLK_MHZ)
`define WICL_PULSE_LONG_CYC (`WICL_PULSE_LONG_US * `WICL_CLK_MHZ)
`endif

/* File: src/wicl_loader.v */
// Purpose: loads wake, attach and indicator defaults from configuration bytes
// Assumes: bytes come from a memory reader on ref_clk; wake pin driven here
// Notes: registers on Avalon-MM, one wait state on every access
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wicl_consts.vh"
module wicl_loader #(
  parameter [31:0] PULSE_SHORT_CYC = `WICL_PULSE_SHORT_CYC,
  parameter [31:0] PULSE_LONG_CYC = `WICL_PULSE_LONG_CYC
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // configuration byte stream
  input wire cfg_valid,
  input wire [2:0] cfg_index,
  input wire [7:0] cfg_data,
  input wire cfg_done,
  output wire cfg_loaded,
  output wire filter0_load,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire avs_waitrequest,
  output reg [31:0] avs_readdata,
  // wake events, same clock
  input wire ev_wake_pin,
  input wire ev_packet,
  input wire ev_frame,
  input wire ev_exact,
  input wire ev_link,
  input wire ev_bcast,
  // attach and mode
  input wire hsic_mode,
  input wire usb_ready,
  // wake event pin
  output reg wake_event_pin_o,
  output reg wake_event_pin_oe,
  // attach pin
  output reg attach_o,
  output reg attach_oe,
  // indicator settings and wake source enables
  output wire [3:0] indicator_enable,
  output wire [15:0] indicator_select,
  output wire [7:0] indicator_behaviour,
  output wire [12:0] wake_source_enable
);
  // ***************
  // load state
  // ***************
  reg loaded_q;
  reg [7:0] wake0_q;
  reg [7:0] wake1_q;
  reg [3:0] ind_en_q;
  reg [15:0] ind_sel_q;
  reg [7:0] ind_beh_q;
  reg protect_q;
  reg ack_q;
  reg frame_ld_q;
  wire acc = (avs_read | avs_write) & ~ack_q;
  wire wr_now = avs_write & ack_q;
  // raised only after the stream ends; wake, attach and indicator_enable wait for it, but indicator_select and indicator_behaviour do not
  assign cfg_loaded = loaded_q;
  assign filter0_load = frame_ld_q;
  always @(posedge ref_clk) begin
    if (reset) begin
      loaded_q <= 1'b0;
      wake0_q <= 8'h00;
      wake1_q <= 8'h00;
      ind_en_q <= 4'h0;
      frame_ld_q <= 1'b0;
    end else begin
      frame_ld_q <= 1'b0;
      if (cfg_valid && !loaded_q) begin
        case (cfg_index)
          `WICL_IDX_WAKE0: wake0_q <= cfg_data;
          `WICL_IDX_WAKE1: wake1_q <= cfg_data & `WICL_W1_MASK;
          `WICL_IDX_IND0: ind_en_q <= cfg_data[3:0];
          default: ind_en_q <= ind_en_q;
        endcase
      end
      if (cfg_done && !loaded_q) begin
        loaded_q <= 1'b1;
        frame_ld_q <= wake1_q[`WICL_W1_FRAME];
      end
      if (wr_now && avs_address == `WICL_REG_FLAG_ATTRIBUTES_REG) begin
        wake0_q <= avs_writedata[7:0];
        wake1_q <= avs_writedata[15:8] & `WICL_W1_MASK;
      end
      if (wr_now && avs_address == `WICL_REG_HARDWARE_CONFIG_REG) begin
        ind_en_q <= avs_writedata[3:0];
      end
    end
  end
  // protection bit itself survives reset so software can keep its values
  reg prot_init_q;
  always @(posedge ref_clk) begin
    if (!prot_init_q) begin
      prot_init_q <= 1'b1;
      protect_q <= 1'b0;
      ind_sel_q <= 16'h0000;
      ind_beh_q <= 8'h00;
    end else begin
      if (wr_now && avs_address == `WICL_REG_HARDWARE_CONFIG_REG) begin
        protect_q <= avs_writedata[`WICL_HW_PROTECT];
      end
      if (reset && !protect_q) begin
        ind_sel_q <= 16'h0000;
        ind_beh_q <= 8'h00;
      end else if (cfg_valid && !loaded_q && !protect_q) begin
        case (cfg_index)
          `WICL_IDX_IND1: ind_sel_q[7:0] <= cfg_data;
          `WICL_IDX_IND2: ind_sel_q[15:8] <= cfg_data;
          `WICL_IDX_IND3: ind_beh_q <= cfg_data;
          default: ind_beh_q <= ind_beh_q;
        endcase
      end else if (wr_now && avs_address == `WICL_REG_IND_MODE) begin
        ind_sel_q <= avs_writedata[15:0];
      end else if (wr_now && avs_address == `WICL_REG_IND_BEH) begin
        ind_beh_q <= avs_writedata[7:0];
      end
    end
  end
  initial prot_init_q = 1'b0;
  // ***************
  // bus slave
  // ***************
  assign avs_waitrequest = acc;
  always @(posedge ref_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= acc;
      if (avs_read && !ack_q) begin
        case (avs_address)
          `WICL_REG_FLAG_ATTRIBUTES_REG: avs_readdata <= {16'h0000, wake1_q, wake0_q};
          `WICL_REG_HARDWARE_CONFIG_REG: avs_readdata <= {22'h000000, loaded_q, protect_q, 4'h0, ind_en_q};
          `WICL_REG_IND_MODE: avs_readdata <= {16'h0000, ind_sel_q};
          `WICL_REG_IND_BEH: avs_readdata <= {24'h000000, ind_beh_q};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
  // ***************
  // wake sources and indicator outputs
  // ***************
  wire master = loaded_q & wake0_q[`WICL_W0_MASTER];
  wire link_en = master & wake0_q[`WICL_W0_LINK];
  wire pkt_en = master & wake0_q[`WICL_W0_PKT];
  wire exact_en = master & wake0_q[`WICL_W0_EXACT];
  wire bcast_en = master & wake1_q[`WICL_W1_BCAST];
  wire frame_en = master & wake1_q[`WICL_W1_FRAME];
  wire pol = wake0_q[`WICL_W0_POL];
  wire wake_ev = master & (ev_wake_pin | (pkt_en & ev_packet) | (frame_en & ev_frame) |
    (exact_en & ev_exact) | (link_en & ev_link) | (bcast_en & ev_bcast));
  assign wake_source_enable = {8'h00, bcast_en, frame_en, exact_en, pkt_en, link_en};
  assign indicator_enable = loaded_q ? ind_en_q : 4'h0;
  assign indicator_select = ind_sel_q;
  assign indicator_behaviour = ind_beh_q;
  // ***************
  // wake pin driver
  // ***************
  reg active_q;
  reg [31:0] cnt_q;
  always @(posedge ref_clk) begin
    if (reset) begin
      active_q <= 1'b0;
      cnt_q <= 32'h00000000;
    end else if (!master) begin
      active_q <= 1'b0;
    end else if (!active_q && wake_ev) begin
      active_q <= 1'b1;
      cnt_q <= wake0_q[`WICL_W0_LONG] ? PULSE_LONG_CYC - 32'h1 : PULSE_SHORT_CYC - 32'h1;
    end else if (active_q && wake0_q[`WICL_W0_PULSE]) begin
      // events during the pulse are ignored so its length is fixed
      if (cnt_q == 32'h0) begin
        active_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end
  always @(posedge ref_clk) begin
    if (reset) begin
      wake_event_pin_o <= 1'b0;
      wake_event_pin_oe <= 1'b0;
    end else if (!master) begin
      wake_event_pin_o <= 1'b0;
      wake_event_pin_oe <= 1'b0;
    end else if (wake0_q[`WICL_W0_PP]) begin
      wake_event_pin_o <= active_q ? pol : ~pol;
      wake_event_pin_oe <= 1'b1;
    end else begin
      // open drain only pulls low; an idle high level needs the pull-up
      wake_event_pin_o <= 1'b0;
      wake_event_pin_oe <= (active_q ? pol : ~pol) == 1'b0;
    end
  end
  // ***************
  // attach pin
  // ***************
  wire att_en = loaded_q & hsic_mode & wake1_q[`WICL_W1_EN];
  wire att_lvl = usb_ready ? wake1_q[`WICL_W1_POL] : ~wake1_q[`WICL_W1_POL];
  always @(posedge ref_clk) begin
    if (reset) begin
      attach_o <= 1'b0;
      attach_oe <= 1'b0;
    end else if (!att_en) begin
      attach_o <= 1'b0;
      attach_oe <= 1'b0;
    end else if (wake1_q[`WICL_W1_PP]) begin
      attach_o <= att_lvl;
      attach_oe <= 1'b1;
    end else begin
      attach_o <= 1'b0;
      attach_oe <= ~att_lvl;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_wicl_loader.sv */
// Purpose: bench for the loader. Assumes: model streams six bytes. Notes: short pulse counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_wicl_loader;
  // stimulus
  logic ref_clk = 1'b0, reset = 1'b1, start = 1'b0, ev_link = 1'b0, hsic_mode = 1'b0, usb_ready = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, ev_wake_pin = 1'b0, ev_packet = 1'b0;
  logic ev_frame = 1'b0, ev_exact = 1'b0, ev_bcast = 1'b0;
  logic [3:0] avs_address = 4'h0, indicator_enable;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [47:0] image = 48'h0;
  // observed
  logic cfg_valid, cfg_done, cfg_loaded, filter0_load, avs_waitrequest;
  logic wake_event_pin_o, wake_event_pin_oe, attach_o, attach_oe;
  logic [2:0] cfg_index;
  logic [7:0] cfg_data, indicator_behaviour;
  logic [15:0] indicator_select;
  logic [12:0] wake_source_enable;
  int fail_count = 0, checks = 0, f0 = 0;
  wicl_loader #(.PULSE_SHORT_CYC(32'h14), .PULSE_LONG_CYC(32'h32)) u_dut (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg_valid(cfg_valid),
    .cfg_index(cfg_index),
    .cfg_data(cfg_data),
    .cfg_done(cfg_done),
    .cfg_loaded(cfg_loaded),
    .filter0_load(filter0_load),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata),
    .ev_wake_pin(ev_wake_pin),
    .ev_packet(ev_packet),
    .ev_frame(ev_frame),
    .ev_exact(ev_exact),
    .ev_link(ev_link),
    .ev_bcast(ev_bcast),
    .hsic_mode(hsic_mode),
    .usb_ready(usb_ready),
    .wake_event_pin_o(wake_event_pin_o),
    .wake_event_pin_oe(wake_event_pin_oe),
    .attach_o(attach_o),
    .attach_oe(attach_oe),
    .indicator_enable(indicator_enable),
    .indicator_select(indicator_select),
    .indicator_behaviour(indicator_behaviour),
    .wake_source_enable(wake_source_enable)
  );
  wicl_cfg_mem u_mem (
    .ref_clk(ref_clk),
    .start(start),
    .image(image),
    .cfg_valid(cfg_valid),
    .cfg_index(cfg_index),
    .cfg_data(cfg_data),
    .cfg_done(cfg_done)
  );
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (filter0_load === 1'b1) f0++;
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic ld(input logic [47:0] img);
    reset <= 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    image <= img;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (40) @(posedge ref_clk);
  endtask
  // raise events in m for h+1 cycles, counting over 72 cycles from the start those on which the wake pin drives
  task automatic ev_count(input logic [5:0] m, input int h, input int e);
    int n;
    n = 0;
    {ev_wake_pin, ev_packet, ev_frame, ev_exact, ev_link, ev_bcast} <= m;
    for (int c = 0; c < 72; c++) begin
      @(posedge ref_clk);
      if (c == h) {ev_wake_pin, ev_packet, ev_frame, ev_exact, ev_link, ev_bcast} <= 6'h00;
      if (wake_event_pin_oe === 1'b1) n++;
    end
    `CHK(n, e)
  endtask
  task automatic pulse_link;
    ev_link <= 1'b1;
    @(posedge ref_clk);
    ev_link <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // reserved wake1 bits set on purpose, level mode, push-pull active high
  task automatic t_load;
    hsic_mode <= 1'b1;
    usb_ready <= 1'b1;
    ld(48'h963CA5F5FF9F);
    rd(4'h0, 32'h0000739F);
    rd(4'h4, 32'h00000205);
    rd(4'h8, 32'h00003CA5);
    rd(4'hC, 32'h00000096);
    rd(4'h2, 32'h00000000);
    `CHK({indicator_enable, indicator_behaviour}, 12'h596)
    `CHK(indicator_select, 16'h3CA5)
    `CHK(cfg_loaded, 1'b1)
    `CHK(wake_source_enable, 13'h001F)
    `CHK(f0, 1)
    `CHK({attach_o, attach_oe}, 2'b11)
    pulse_link();
    `CHK({wake_event_pin_o, wake_event_pin_oe}, 2'b11)
    hsic_mode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(attach_oe, 1'b0)
  endtask
  // master clear: wake0 bits 4..0 set but must be disregarded
  task automatic t_master_off;
    hsic_mode <= 1'b1;
    ld(48'h00000000001F);
    `CHK(wake_source_enable, 13'h0000)
    `CHK(f0, 1)
    pulse_link();
    `CHK(wake_event_pin_oe, 1'b0)
    `CHK(attach_oe, 1'b0)
  endtask
  // pulse mode, open drain, active low; link change left disabled
  task automatic t_pulse;
    ld(48'h0000000003C3);
    `CHK({wake_event_pin_o, wake_event_pin_oe}, 2'b00)
    `CHK(wake_source_enable, 13'h001E)
    `CHK(f0, 2)
    ev_count(6'h20, 0, 20);
    ev_count(6'h20, 10, 20);
    ev_count(6'h10, 0, 20);
    ev_count(6'h08, 0, 20);
    ev_count(6'h04, 0, 20);
    ev_count(6'h02, 0, 0);
    ev_count(6'h01, 0, 20);
    // long pulse; attach pin open drain, active low
    ld(48'h0000000022E0);
    `CHK(f0, 2)
    ev_count(6'h10, 0, 0);
    ev_count(6'h01, 0, 50);
    `CHK({attach_o, attach_oe}, 2'b01)
    usb_ready <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK({attach_o, attach_oe}, 2'b00)
  endtask
  task automatic t_protect;
    wr(4'h4, 32'h00000100);
    wr(4'h8, 32'h00001234);
    wr(4'hC, 32'h0000005A);
    ld(48'h112233440080);
    rd(4'h8, 32'h00001234);
    rd(4'hC, 32'h0000005A);
    rd(4'h4, 32'h00000304);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    t_load();
    t_master_off();
    t_pulse();
    t_protect();
    give_verdict();
  end
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule
bind wicl_loader wicl_monitor u_mon (
  .ref_clk(ref_clk),
  .reset(reset),
  .cfg_done(cfg_done),
  .cfg_loaded(cfg_loaded),
  .filter0_load(filter0_load),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .hsic_mode(hsic_mode),
  .attach_oe(attach_oe),
  .wake_event_pin_oe(wake_event_pin_oe),
  .avs_readdata(avs_readdata),
  .indicator_enable(indicator_enable),
  .wake_source_enable(wake_source_enable)
);
`default_nettype wire

/* File: verif/wicl_cfg_mem.sv */
// Purpose: configuration memory model. Assumes: start pulse. Notes: idle gaps between bytes
`timescale 1ns/1ps
`default_nettype none
module wicl_cfg_mem (
  // control
  input wire logic ref_clk,
  input wire logic start,
  input wire logic [47:0] image,
  // byte stream
  output logic cfg_valid = 1'b0,
  output logic [2:0] cfg_index = 3'h0,
  output logic [7:0] cfg_data = 8'hA5,
  output logic cfg_done = 1'b0
);
  // uneven gaps mimic a slow serial read; data is not held once valid drops
  always begin
    @(posedge ref_clk);
    if (start === 1'b1) begin
      for (int i = 0; i < 6; i++) begin
        cfg_valid <= 1'b1;
        cfg_index <= i[2:0];
        cfg_data <= image[8*i +: 8];
        @(posedge ref_clk);
        cfg_valid <= 1'b0;
        cfg_data <= ~image[8*i +: 8];
        repeat (i % 2 + 1) @(posedge ref_clk);
      end
      cfg_done <= 1'b1;
      @(posedge ref_clk);
      cfg_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: verif/wicl_monitor.sv */
// Purpose: port checks for the loader. Assumes: one clock. Notes: bound from the bench
`timescale 1ns/1ps
`default_nettype none
module wicl_monitor (
  // clock, reset and stream
  input wire logic ref_clk, reset, cfg_done, cfg_loaded, filter0_load,
  // bus and pins
  input wire logic avs_read, avs_write, avs_waitrequest, hsic_mode, attach_oe, wake_event_pin_oe,
  input wire logic [31:0] avs_readdata,
  input wire logic [3:0] indicator_enable,
  input wire logic [12:0] wake_source_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_one_wait: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait wrong");
  a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  a_idle_pins: assert property (!cfg_loaded |-> !wake_event_pin_oe && !attach_oe && indicator_enable == 4'h0)
    else $error("pin active early");
  a_no_source: assert property (!cfg_loaded |-> wake_source_enable == 13'h0000)
    else $error("source early");
  a_upper_zero: assert property (wake_source_enable[12:5] == 8'h00)
    else $error("upper sources set");
  a_load_kept: assert property (cfg_loaded |=> cfg_loaded)
    else $error("loaded dropped");
  a_load_cause: assert property ($rose(cfg_loaded) |-> $past(cfg_done))
    else $error("loaded without done");
  a_filter_pulse: assert property (filter0_load |-> $past(cfg_done) ##1 !filter0_load)
    else $error("filter pulse wrong");
  a_attach_mode: assert property (!hsic_mode && !$past(hsic_mode) |-> !attach_oe)
    else $error("attach outside mode");
endmodule
`default_nettype wire
